// file: design/fccs_params.svh
/*
 * Constants of the flash charger control sequencer: timing counts,
 * register offsets, field positions and reset values.
 * Assumes a 200 MHz core clock; every timing count is derived from a time.
 */
`ifndef FCCS_PARAMS_SVH
`define FCCS_PARAMS_SVH

// Core clock rate
`define FCCS_CLK_MHZ 200
// Longest on-time and timer off-time, in microseconds
`define FCCS_T_MAX_US 18
`define FCCS_T_MAX_CYC (`FCCS_T_MAX_US * `FCCS_CLK_MHZ)
// Setting decode time after the first programming edge, in microseconds
`define FCCS_SETUP_US 200
`define FCCS_SETUP_CYC (`FCCS_SETUP_US * `FCCS_CLK_MHZ)
// Least off-interval before the output sample is trusted, in nanoseconds
`define FCCS_SAMPLE_NS 200
`define FCCS_SAMPLE_CYC ((`FCCS_SAMPLE_NS * `FCCS_CLK_MHZ + 999) / 1000)
// Highest count of extra programming pulses
`define FCCS_MAX_EXTRA 15

// Register byte offsets
`define FCCS_REG_CTRL 8'h00
`define FCCS_REG_STATUS 8'h04
`define FCCS_REG_SETTING 8'h08
// Control fields and reset values
`define FCCS_CTRL_ALLOW_BIT 0
`define FCCS_CTRL_TIMER_BIT 1
`define FCCS_CTRL_RESET 2'h1
// Status fields
`define FCCS_ST_STATE_LSB 0
`define FCCS_ST_SWITCH_BIT 3
`define FCCS_ST_DONE_BIT 4
`define FCCS_ST_SUPPLY_LOW_LOCKOUT_BIT 5
`define FCCS_ST_TIMER_BIT 6
// Setting fields
`define FCCS_SET_CODE_LSB 0
`define FCCS_SET_PCT_LSB 8

`endif

// file: design/fccs_pkg.sv
/*
 * Types of the flash charger control sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fccs_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_SETUP   = 3'b001,
        ST_ON      = 3'b010,
        ST_OFF     = 3'b011,
        ST_DONE    = 3'b100,
        ST_BLOCKED = 3'b101
    } fccs_state_t;

endpackage : fccs_pkg

// file: design/fccs_sync_if.sv
/*
 * Carrier of the synchronised host levels and edges between the input
 * synchroniser and the sequencer. Assumes one clock domain.
 */
interface fccs_sync_if;
    logic charge_lvl;
    logic charge_rise;
    logic flash_trigger_in_lvl;

    modport src (output charge_lvl, output charge_rise, output flash_trigger_in_lvl);
    modport dst (input charge_lvl, input charge_rise, input flash_trigger_in_lvl);
endinterface : fccs_sync_if

// file: design/fccs_sync.sv
/*
 * Two-stage synchronisers for charge enable and flash trigger, plus the
 * rising-edge detect of charge enable. Assumes asynchronous host pins.
 */
module fccs_sync (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Host pins
    input wire logic charge_en_in,
    input wire logic flash_trigger_in,
    // Synchronised side
    fccs_sync_if.src sync
);
    logic [2:0] chg_r, chg_nxt;
    logic [1:0] trg_r, trg_nxt;
    logic rise_r, rise_nxt;

    // Edge taken between stages two and three, never on the first stage
    always_comb begin
        chg_nxt = chg_r;
        trg_nxt = trg_r;
        rise_nxt = rise_r;
        if (ce) begin
            chg_nxt = {chg_r[1:0], charge_en_in};
            trg_nxt = {trg_r[0], flash_trigger_in};
            rise_nxt = chg_r[1] & ~chg_r[2];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            chg_r <= 3'h0;
            trg_r <= 2'h0;
            rise_r <= 1'b0;
        end else begin
            chg_r <= chg_nxt;
            trg_r <= trg_nxt;
            rise_r <= rise_nxt;
        end
    end

    // Level aligned with the registered edge
    assign sync.charge_lvl = chg_r[2];
    assign sync.charge_rise = rise_r;
    assign sync.flash_trigger_in_lvl = trg_r[1];
endmodule : fccs_sync

// file: design/fccs_pct_rom.sv
/*
 * Peak current percentage table, one entry per extra programming pulse.
 * Read data is registered; one cycle from address to data.
 */
module fccs_pct_rom (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Lookup
    input wire logic [3:0] addr,
    output logic [6:0] pct_r
);
    logic [6:0] pct_nxt;

    // Percent of the full 1.5 A limit
    function automatic logic [6:0] fccs_pct(input logic [3:0] code);
        case (code)
            4'h0: fccs_pct = 7'h64;
            4'h1: fccs_pct = 7'h5F;
            4'h2: fccs_pct = 7'h5A;
            4'h3: fccs_pct = 7'h56;
            4'h4: fccs_pct = 7'h51;
            4'h5: fccs_pct = 7'h4C;
            4'h6: fccs_pct = 7'h47;
            4'h7: fccs_pct = 7'h43;
            4'h8: fccs_pct = 7'h3E;
            4'h9: fccs_pct = 7'h39;
            4'hA: fccs_pct = 7'h34;
            4'hB: fccs_pct = 7'h30;
            4'hC: fccs_pct = 7'h2B;
            4'hD: fccs_pct = 7'h26;
            4'hE: fccs_pct = 7'h21;
            default: fccs_pct = 7'h1D;
        endcase
    endfunction : fccs_pct

    // Table read
    always_comb begin
        pct_nxt = ce ? fccs_pct(addr) : pct_r;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pct_r <= 7'h64;
        end else begin
            pct_r <= pct_nxt;
        end
    end
endmodule : fccs_pct_rom

// file: design/fccs_sequencer.sv
/*
 * Flash charger control sequencer: charge start/stop, setting decode,
 * on/off-time control, completion flag, strobe drive and a Wishbone
 * register slave. Assumes analog comparators arrive as synchronous levels
 * and that the host keeps to the programming pulse timing.
 */
`include "fccs_params.svh"

// Behaviour
// - Rising enable starts charging unless supply low; the code also blocks it when the control allow bit is clear
// - Output trip stops switching
// - Restart only on new rising enable
// - Enable low means standby, no switching
// - Edge during lockout ignored, await next edge
// - Strobe drive follows trigger level
// - Completion flag low when done, enable high
// - Full current default, fifteen lower steps
// - Current limit hit turns switch off
// - Next cycle at flux reset or timeout
// - On-time capped at 18 us
// - Low output uses fixed 18 us off-time
// - 200 us decode before current ramps
// - Output sampled after 200 ns off-time
// - First edge starts decoder, sixteen edges counted
// - Setting held while high, low resets
// - Extra pulses map to descending percentages
// - Flag released while charging or enable low
module fccs_sequencer #(
    parameter int TMAX_CYC = `FCCS_T_MAX_CYC,
    parameter int SETUP_CYC = `FCCS_SETUP_CYC,
    parameter int SAMPLE_CYC = `FCCS_SAMPLE_CYC
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // Host pins
    input wire logic charge_en_in,
    input wire logic flash_trigger_in,
    output logic done_out_r,
    output logic done_oe_n_r,
    output logic strobe_drive_r,
    // Analog comparators and supply
    input wire logic supply_low_lockout,
    input wire logic switch_current_limit,
    input wire logic output_trip_level,
    input wire logic flux_reset,
    input wire logic output_below_fast,
    // Power stage
    output logic switch_on_r,
    output logic [3:0] peak_current_setting_r,
    output logic [6:0] peak_current_pct_r,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    localparam logic [15:0] TMAX_LAST = 16'(TMAX_CYC - 1);
    localparam logic [15:0] SETUP_LAST = 16'(SETUP_CYC - 1);
    localparam logic [15:0] SAMPLE_MIN = 16'(SAMPLE_CYC);

    fccs_sync_if sync_if ();
    fccs_pkg::fccs_state_t state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [3:0] pulses_r, pulses_nxt;
    logic [3:0] setting_nxt;
    logic switch_nxt, done_oe_n_nxt, strobe_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [31:0] rdata_nxt;
    logic ack_nxt;
    logic timer_mode, sample_ok, allow;

    // Host inputs cross into the clock domain first
    fccs_sync u_sync (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .charge_en_in(charge_en_in),
        .flash_trigger_in(flash_trigger_in),
        .sync(sync_if.src)
    );

    // Percentage lookup follows the live setting
    fccs_pct_rom u_rom (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .addr(peak_current_setting_r),
        .pct_r(peak_current_pct_r)
    );

    // Mode and sample qualifiers
    assign timer_mode = output_below_fast | ctrl_r[`FCCS_CTRL_TIMER_BIT];
    assign sample_ok = (cnt_r >= SAMPLE_MIN);
    assign allow = ctrl_r[`FCCS_CTRL_ALLOW_BIT] & ~supply_low_lockout;

    // Sequencer next state; the counter times setup, on and off intervals
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        pulses_nxt = pulses_r;
        setting_nxt = peak_current_setting_r;
        case (state_r)
            fccs_pkg::ST_STANDBY: begin
                setting_nxt = 4'h0;
                pulses_nxt = 4'h0;
                cnt_nxt = 16'h0000;
                if (sync_if.charge_rise) begin
                    state_nxt = allow ? fccs_pkg::ST_SETUP : fccs_pkg::ST_BLOCKED;
                end
            end
            fccs_pkg::ST_SETUP: begin
                // Short lows between pulses must not abort decoding
                cnt_nxt = cnt_r + 16'h0001;
                if (sync_if.charge_rise && pulses_r != 4'(`FCCS_MAX_EXTRA)) begin
                    pulses_nxt = pulses_r + 4'h1;
                end
                if (cnt_r == SETUP_LAST) begin
                    cnt_nxt = 16'h0000;
                    setting_nxt = pulses_nxt;
                    state_nxt = sync_if.charge_lvl ? fccs_pkg::ST_ON : fccs_pkg::ST_STANDBY;
                end
            end
            fccs_pkg::ST_ON: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (switch_current_limit || cnt_r == TMAX_LAST) begin
                    cnt_nxt = 16'h0000;
                    state_nxt = fccs_pkg::ST_OFF;
                end
            end
            fccs_pkg::ST_OFF: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (sample_ok && output_trip_level) begin
                    state_nxt = fccs_pkg::ST_DONE;
                end else if (cnt_r == TMAX_LAST || (!timer_mode && sample_ok && flux_reset)) begin
                    cnt_nxt = 16'h0000;
                    state_nxt = fccs_pkg::ST_ON;
                end
            end
            fccs_pkg::ST_DONE: begin
                cnt_nxt = 16'h0000; // Leaves only through standby
            end
            fccs_pkg::ST_BLOCKED: begin
                cnt_nxt = 16'h0000; // Waits for enable low then a new edge
            end
            default: begin
                state_nxt = fccs_pkg::ST_STANDBY;
            end
        endcase
        // Supply loss mid-session needs a fresh edge to resume
        if ((state_r == fccs_pkg::ST_ON || state_r == fccs_pkg::ST_OFF) && supply_low_lockout) begin
            state_nxt = fccs_pkg::ST_BLOCKED;
        end
        // Enable low ends any session outside the decode window
        if (!sync_if.charge_lvl && state_r != fccs_pkg::ST_SETUP) begin
            state_nxt = fccs_pkg::ST_STANDBY;
        end
        if (!ce) begin
            state_nxt = state_r;
            cnt_nxt = cnt_r;
            pulses_nxt = pulses_r;
            setting_nxt = peak_current_setting_r;
        end
    end

    // Switch and flag outputs derived from the coming state so they align with it; strobe from the trigger level
    always_comb begin
        switch_nxt = (state_nxt == fccs_pkg::ST_ON);
        done_oe_n_nxt = ~(state_nxt == fccs_pkg::ST_DONE && sync_if.charge_lvl);
        strobe_nxt = sync_if.flash_trigger_in_lvl;
        if (!ce) begin
            switch_nxt = switch_on_r;
            done_oe_n_nxt = done_oe_n_r;
            strobe_nxt = strobe_drive_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= fccs_pkg::ST_STANDBY;
            cnt_r <= 16'h0000;
            pulses_r <= 4'h0;
            peak_current_setting_r <= 4'h0;
            switch_on_r <= 1'b0;
            done_oe_n_r <= 1'b1;
            done_out_r <= 1'b0;
            strobe_drive_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pulses_r <= pulses_nxt;
            peak_current_setting_r <= setting_nxt;
            switch_on_r <= switch_nxt;
            done_oe_n_r <= done_oe_n_nxt;
            done_out_r <= 1'b0; // Open drain only ever pulls low
            strobe_drive_r <= strobe_nxt;
        end
    end

    // Wishbone slave: ack one cycle after the request, dropped the next
    always_comb begin
        ctrl_nxt = ctrl_r;
        rdata_nxt = wb_dat_o;
        ack_nxt = 1'b0;
        if (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            ack_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000; // Unmapped reads return zero
            if (!wb_we_i) begin
                case (wb_adr_i)
                    `FCCS_REG_CTRL: rdata_nxt[1:0] = ctrl_r;
                    `FCCS_REG_STATUS: begin
                        rdata_nxt[`FCCS_ST_STATE_LSB +: 3] = state_r;
                        rdata_nxt[`FCCS_ST_SWITCH_BIT] = switch_on_r;
                        rdata_nxt[`FCCS_ST_DONE_BIT] = ~done_oe_n_r;
                        rdata_nxt[`FCCS_ST_SUPPLY_LOW_LOCKOUT_BIT] = supply_low_lockout;
                        rdata_nxt[`FCCS_ST_TIMER_BIT] = timer_mode;
                    end
                    `FCCS_REG_SETTING: begin
                        rdata_nxt[`FCCS_SET_CODE_LSB +: 4] = peak_current_setting_r;
                        rdata_nxt[`FCCS_SET_PCT_LSB +: 7] = peak_current_pct_r;
                    end
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
        end else if (!ce) begin
            ack_nxt = wb_ack_o;
        end
        // Write lands on the edge where the master sees ack
        if (ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            if (wb_adr_i == `FCCS_REG_CTRL && wb_sel_i[0]) begin
                ctrl_nxt = wb_dat_i[1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl_r <= `FCCS_CTRL_RESET;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            wb_dat_o <= rdata_nxt;
            wb_ack_o <= ack_nxt;
        end
    end

    // Checks on the sequencer
    a_start_on_edge: assert property (@(posedge clock) disable iff (!rstn || !ce)
        state_r == fccs_pkg::ST_STANDBY && sync_if.charge_rise && allow |=> state_r == fccs_pkg::ST_SETUP)
        else $error("rising enable did not start decode");
    a_lockout_blocks: assert property (@(posedge clock) disable iff (!rstn || !ce)
        state_r == fccs_pkg::ST_STANDBY && sync_if.charge_rise && supply_low_lockout
        |=> state_r == fccs_pkg::ST_BLOCKED ##1 !switch_on_r)
        else $error("edge during lockout started charging");
    a_low_standby: assert property (@(posedge clock) disable iff (!rstn || !ce)
        !sync_if.charge_lvl && state_r != fccs_pkg::ST_SETUP |=> state_r == fccs_pkg::ST_STANDBY && !switch_on_r)
        else $error("enable low did not halt switching");
    a_trip_stops: assert property (@(posedge clock) disable iff (!rstn || !ce)
        state_r == fccs_pkg::ST_OFF && sample_ok && output_trip_level && sync_if.charge_lvl && !supply_low_lockout
        |=> state_r == fccs_pkg::ST_DONE && !switch_on_r && !done_oe_n_r)
        else $error("trip did not stop switching");
    a_strobe_follows: assert property (@(posedge clock) disable iff (!rstn || !ce)
        strobe_drive_r == $past(sync_if.flash_trigger_in_lvl))
        else $error("strobe drive does not follow trigger");
    a_flag_released: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == fccs_pkg::ST_ON || state_r == fccs_pkg::ST_OFF || state_r == fccs_pkg::ST_STANDBY) |-> done_oe_n_r)
        else $error("completion flag low while not done");
    a_limit_off: assert property (@(posedge clock) disable iff (!rstn || !ce)
        state_r == fccs_pkg::ST_ON && switch_current_limit |=> !switch_on_r)
        else $error("current limit did not open switch");
    a_on_bounded: assert property (@(posedge clock) disable iff (!rstn)
        state_r == fccs_pkg::ST_ON |-> cnt_r <= TMAX_LAST)
        else $error("on-time exceeded its cap");
    a_off_min: assert property (@(posedge clock) disable iff (!rstn || !ce)
        state_r == fccs_pkg::ST_OFF && cnt_r < SAMPLE_MIN |=> state_r != fccs_pkg::ST_ON && state_r != fccs_pkg::ST_DONE)
        else $error("off-interval shorter than sample time");
    a_setup_quiet: assert property (@(posedge clock) disable iff (!rstn)
        state_r == fccs_pkg::ST_SETUP |-> !switch_on_r && cnt_r <= SETUP_LAST)
        else $error("switch on during setting decode");
    a_setting_reset: assert property (@(posedge clock) disable iff (!rstn || !ce)
        state_r == fccs_pkg::ST_STANDBY |=> peak_current_setting_r == 4'h0)
        else $error("setting kept through enable low");
endmodule : fccs_sequencer

// file: verif/fccs_plant_model.sv
/*
 * Power stage model: the comparator levels that face the sequencer.
 * Assumes one clock; the bench sets each count, 0 meaning never.
 */
module fccs_plant_model (
    // Clock, reset, session clear
    input wire logic clock,
    input wire logic rstn,
    input wire logic clr,
    // Gate and scenario counts
    input wire logic switch_on_r,
    input wire logic [7:0] lim_cyc,
    input wire logic [7:0] flux_cyc,
    input wire logic [7:0] trip_n,
    input wire logic [7:0] fast_n,
    // Comparator levels
    output logic switch_current_limit,
    output logic flux_reset,
    output logic output_trip_level,
    output logic output_below_fast
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] on_r;
    logic [7:0] off_r;
    logic [7:0] n_r;
    logic sw_r;

    // Ramp time, ring time and pulse tally; off count saturates
    always_ff @(posedge clock) begin
        if (!rstn || clr) begin
            on_r <= 8'h00;
            off_r <= 8'h00;
            n_r <= 8'h00;
            sw_r <= 1'b0;
        end else begin
            sw_r <= switch_on_r;
            on_r <= switch_on_r ? on_r + 8'h01 : 8'h00;
            off_r <= switch_on_r ? 8'h00 : (off_r == 8'hFF ? 8'hFF : off_r + 8'h01);
            n_r <= n_r + 8'(switch_on_r && !sw_r);
        end
    end

    // Levels; no current flows while the gate is off
    assign switch_current_limit = switch_on_r && lim_cyc != 8'h00 && on_r >= lim_cyc;
    assign flux_reset = !switch_on_r && flux_cyc != 8'h00 && off_r >= flux_cyc;
    assign output_trip_level = trip_n != 8'h00 && n_r >= trip_n;
    assign output_below_fast = n_r < fast_n;
endmodule : fccs_plant_model

// file: verif/test_flash_charger_control_sequencer.sv
/*
 * Self-checking bench of the charger sequencer: host pin stimulus,
 * Wishbone accesses and a power stage model. Assumes shortened counts.
 */
`include "fccs_params.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch %s expected %0h seen %0h", what, exp, got); end end

module test_flash_charger_control_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TMAX = 20;
    localparam int SETUP = 1400;
    localparam int SAMPLE = 4;
    localparam int LIMIT = 60000;
    localparam logic [6:0] PCT [16] = '{7'h64, 7'h5F, 7'h5A, 7'h56, 7'h51, 7'h4C, 7'h47, 7'h43,
        7'h3E, 7'h39, 7'h34, 7'h30, 7'h2B, 7'h26, 7'h21, 7'h1D};
    logic clock, rstn, ce, charge_en_in, flash_trigger_in, supply_low_lockout, clr;
    logic switch_current_limit, output_trip_level, flux_reset, output_below_fast;
    logic done_out_r, done_oe_n_r, strobe_drive_r, switch_on_r;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0] peak_current_setting_r, wb_sel_i;
    logic [6:0] peak_current_pct_r;
    logic [7:0] wb_adr_i, lim, flux, trip, fast;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    int n_fail, total_checks, cyc, t0, on_w, off_w, g;
    bit seen;

    fccs_sequencer #(.TMAX_CYC(TMAX), .SETUP_CYC(SETUP), .SAMPLE_CYC(SAMPLE)) i_fccs_sequencer (
        .clock, .rstn, .ce, .charge_en_in, .flash_trigger_in, .done_out_r, .done_oe_n_r,
        .strobe_drive_r, .supply_low_lockout, .switch_current_limit, .output_trip_level,
        .flux_reset, .output_below_fast, .switch_on_r, .peak_current_setting_r,
        .peak_current_pct_r, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o);
    fccs_plant_model i_fccs_plant_model (.clock, .rstn, .clr, .switch_on_r, .lim_cyc(lim),
        .flux_cyc(flux), .trip_n(trip), .fast_n(fast), .switch_current_limit, .flux_reset,
        .output_trip_level, .output_below_fast);

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Cycle count, also the guard against a hang
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Classic Wishbone cycle; entered just after an edge, held until ack
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] v, input logic [3:0] s);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= v;
        // No local timeout; ack ends this wait, or the bench ceiling if ack never comes
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask : wb

    task automatic pin(input logic v, input int n);
        charge_en_in <= v;
        repeat (n) @(posedge clock);
    endtask : pin

    // First pulse is long, scaled with the shortened setup window
    task automatic start(input int k);
        t0 = cyc;
        pin(1'b1, 60);
        for (int i = 0; i < k; i++) begin
            pin(1'b0, 40);
            pin(1'b1, 40);
        end
    endtask : start

    task automatic stop();
        pin(1'b0, 8);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        `CHK("switch_idle", 1'b0, switch_on_r)
        `CHK("flag_idle", 1'b1, done_oe_n_r)
    endtask : stop

    task automatic wait_on();
        g = 0;
        while (switch_on_r !== 1'b1 && g < 2000) begin
            @(posedge clock);
            g++;
        end
    endtask : wait_on

    // Width of the first on-interval and the off-interval after it
    task automatic measure();
        wait_on();
        on_w = 0;
        off_w = 0;
        while (switch_on_r === 1'b1 && on_w < 500) begin
            @(posedge clock);
            on_w++;
        end
        while (switch_on_r !== 1'b1 && off_w < 500) begin
            @(posedge clock);
            off_w++;
        end
    endtask : measure

    task automatic watch(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(posedge clock);
            if (switch_on_r !== 1'b0) seen = 1'b1;
        end
    endtask : watch

    // Main sequence; enable is low from time zero through power-up
    initial begin
        {rstn, charge_en_in, flash_trigger_in, supply_low_lockout, clr} = 5'h00;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {ce, lim, flux, trip, fast} = {1'b1, 8'h05, 8'h00, 8'h00, 8'h08};
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        `CHK("pct_reset", 7'h64, peak_current_pct_r)
        `CHK("setting_reset", 4'h0, peak_current_setting_r)
        `CHK("flag_reset", 1'b1, done_oe_n_r)
        // Register bus: lane-gated write, unmapped place
        wb(`FCCS_REG_CTRL, 1'b1, 32'h3, 4'hF);
        wb(`FCCS_REG_CTRL, 1'b0, 32'h0, 4'hF);
        `CHK("ctrl_set", 32'h3, d)
        wb(`FCCS_REG_CTRL, 1'b1, 32'h1, 4'h1);
        wb(`FCCS_REG_CTRL, 1'b1, 32'h0, 4'hE);
        wb(`FCCS_REG_CTRL, 1'b0, 32'h0, 4'hF);
        `CHK("ctrl", 32'h1, d)
        wb(8'h10, 1'b1, 32'hFFFFFFFF, 4'hF);
        wb(8'h10, 1'b0, 32'h0, 4'hF);
        `CHK("unmapped", 32'h0, d)
        // Strobe follows trigger; triggers kept out of charging
        flash_trigger_in <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK("strobe_hi", 1'b1, strobe_drive_r)
        flash_trigger_in <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK("strobe_lo", 1'b0, strobe_drive_r)
        // Rising edge under lockout, then recovery without a new edge
        supply_low_lockout <= 1'b1;
        start(0);
        watch(SETUP + 20);
        `CHK("lockout_idle", 1'b0, seen)
        wb(`FCCS_REG_STATUS, 1'b0, 32'h0, 4'hF);
        `CHK("state_blocked", fccs_pkg::ST_BLOCKED, d[2:0])
        supply_low_lockout <= 1'b0;
        watch(40);
        `CHK("recover_idle", 1'b0, seen)
        pin(1'b0, 8);
        // Timer mode: current limit ends on-time, fixed off-time
        start(0);
        measure();
        `CHK("on_limit", 1'b1, (on_w > 0 && on_w < TMAX))
        `CHK("off_timer", TMAX, off_w)
        `CHK("flag_charging", 1'b1, done_oe_n_r)
        stop();
        // Fast mode: on-time cap, early restart on flux reset
        {lim, flux, fast} <= {8'h00, 8'h06, 8'h00};
        start(0);
        measure();
        `CHK("on_cap", TMAX, on_w)
        `CHK("off_flux", 1'b1, (off_w >= SAMPLE && off_w < TMAX))
        stop();
        // Completion: trip stops switching, flag low, no restart
        {lim, trip} <= {8'h05, 8'h03};
        start(0);
        g = 0;
        while (done_oe_n_r !== 1'b0 && g < 2000) begin
            @(posedge clock);
            g++;
        end
        `CHK("flag_done", 1'b0, done_oe_n_r)
        `CHK("switch_done", 1'b0, switch_on_r)
        `CHK("flag_data", 1'b0, done_out_r)
        watch(100);
        `CHK("no_restart", 1'b0, seen)
        wb(`FCCS_REG_STATUS, 1'b0, 32'h0, 4'hF);
        `CHK("state_done", fccs_pkg::ST_DONE, d[2:0])
        stop();
        // Every pulse count: decode wait, code, percentage, clear on low
        trip <= 8'h00;
        for (int k = 0; k < 16; k++) begin
            start(k);
            wait_on();
            `CHK("setup_wait", 1'b1, (cyc - t0 >= SETUP && cyc - t0 <= SETUP + 8))
            repeat (2) @(posedge clock);
            `CHK("code", 4'(k), peak_current_setting_r)
            `CHK("pct", PCT[k], peak_current_pct_r)
            stop();
            `CHK("code_clear", 4'h0, peak_current_setting_r)
        end
        conclude();
    end
endmodule : test_flash_charger_control_sequencer
